// >>> core/mbl_pkg.sv
package mbl_pkg;
    localparam int NUM_BANKS         = 8;
    localparam int BANK_W            = 3;
    localparam int CNT_W             = 8;
    // timing figures in clocks, defaults for the bank tracker
    localparam int DEF_BURST_LENGTH  = 4;
    localparam int DEF_WRITE_LAT     = 4;
    localparam int DEF_READ_LAT_RND  = 8;
    localparam int DEF_ROW_TO_COL    = 5;
    localparam int DEF_WRITE_RECOV   = 4;
    localparam int DEF_ROW_PRECHARGE = 6;
    localparam int ONE_CLOCK         = 1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // per-bank state codes
    typedef enum logic [2:0] {
        BK_IDLE       = 3'b000,
        BK_ACTIVATING = 3'b001,
        BK_ACTIVE     = 3'b010,
        BK_READ       = 3'b011,
        BK_WRITE      = 3'b100,
        BK_RD_AP      = 3'b101,
        BK_WR_AP      = 3'b110,
        BK_PRECHARGE  = 3'b111
    } mbl_bank_type;

    // decoded command (chip select, row, column, write enable)
    typedef enum logic [3:0] {
        CMD_DESELECT  = 4'h0,
        CMD_NOP       = 4'h1,
        CMD_ACTIVE    = 4'h2,
        CMD_READ      = 4'h3,
        CMD_WRITE     = 4'h4,
        CMD_PRECHARGE = 4'h5,
        CMD_REFRESH   = 4'h6,
        CMD_LOAD_MODE = 4'h7,
        CMD_TERM_DIS  = 4'h8
    } mbl_cmd_type;
endpackage

// >>> core/mbl_cmd_if.sv
`timescale 1ns/1ps
// decoded command handed from the top to the bank tracker
interface mbl_cmd_if;
    import mbl_pkg::*;
    logic                  cmdValid;
    mbl_cmd_type           cmd;
    logic [BANK_W-1:0]     bank;
    logic                  autoPre;
    logic [NUM_BANKS-1:0]  bankIdle;
    modport src (output cmdValid, output cmd, output bank, output autoPre, input bankIdle);
    modport trk (input cmdValid, input cmd, input bank, input autoPre, output bankIdle);
endinterface

// >>> core/mbl_bank_track.sv
`timescale 1ns/1ps
// one state machine and timer per bank
module mbl_bank_track
    import mbl_pkg::*;
#(
    parameter int BURST_LENGTH  = DEF_BURST_LENGTH,
    parameter int WRITE_LAT     = DEF_WRITE_LAT,
    parameter int READ_LAT_RND  = DEF_READ_LAT_RND,
    parameter int ROW_TO_COL    = DEF_ROW_TO_COL,
    parameter int WRITE_RECOV   = DEF_WRITE_RECOV,
    parameter int ROW_PRECHARGE = DEF_ROW_PRECHARGE
) (
    input  wire logic  sys_clk,
    input  wire logic  rstN,
    mbl_cmd_if.trk     cmdIf,
    output mbl_bank_type bankState [NUM_BANKS]
);
    // read: data out, then earliest precharge half a burst after the command
    localparam logic [CNT_W-1:0] RD_ACCESS = CNT_W'(BURST_LENGTH / 2);
    localparam logic [CNT_W-1:0] WR_ACCESS =
        CNT_W'(WRITE_LAT + BURST_LENGTH / 2 + WRITE_RECOV);
    localparam logic [CNT_W-1:0] RCD_CNT = CNT_W'(ROW_TO_COL);
    localparam logic [CNT_W-1:0] RP_CNT  = CNT_W'(ROW_PRECHARGE);

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : gBank
            mbl_bank_type    state_ff;
            logic [CNT_W-1:0] cnt_ff;
            logic            hit;
            assign hit = cmdIf.cmdValid && (cmdIf.bank == BANK_W'(g));
            assign bankState[g] = state_ff;
            assign cmdIf.bankIdle[g] = (state_ff == BK_IDLE);

            // bank state update; counts run to zero then advance
            always_ff @(posedge sys_clk or negedge rstN) begin
                if (!rstN) begin
                    state_ff <= BK_IDLE;
                    cnt_ff   <= CNT_ZERO;
                end else if (hit && cmdIf.cmd == CMD_ACTIVE) begin
                    state_ff <= BK_ACTIVATING;
                    cnt_ff   <= RCD_CNT;
                end else if (hit && (cmdIf.cmd == CMD_READ || cmdIf.cmd == CMD_WRITE)) begin
                    if (cmdIf.cmd == CMD_READ) begin
                        state_ff <= cmdIf.autoPre ? BK_RD_AP : BK_READ;
                        cnt_ff   <= RD_ACCESS;
                    end else begin
                        state_ff <= cmdIf.autoPre ? BK_WR_AP : BK_WRITE;
                        cnt_ff   <= WR_ACCESS;
                    end
                end else if (hit && cmdIf.cmd == CMD_PRECHARGE) begin
                    state_ff <= BK_PRECHARGE;
                    cnt_ff   <= RP_CNT;
                end else if (cnt_ff != CNT_ZERO) begin
                    cnt_ff <= cnt_ff - CNT_W'(ONE_CLOCK);
                end else begin
                    case (state_ff)
                        BK_ACTIVATING: state_ff <= BK_ACTIVE;
                        BK_READ, BK_WRITE: state_ff <= BK_ACTIVE;
                        BK_RD_AP, BK_WR_AP: begin
                            state_ff <= BK_PRECHARGE;
                            cnt_ff   <= RP_CNT;
                        end
                        BK_PRECHARGE: state_ff <= BK_IDLE;
                        default: state_ff <= state_ff;
                    endcase
                end
            end

            AST_PRE_TO_IDLE: assert property (@(posedge sys_clk) disable iff (!rstN)
                (state_ff == BK_PRECHARGE && cnt_ff == RP_CNT && !hit)
                    |-> (state_ff == BK_PRECHARGE) [*7] ##1 (state_ff == BK_IDLE))
                else $error("bank left precharge early or late");
            AST_WRAP_PRE: assert property (@(posedge sys_clk) disable iff (!rstN)
                (state_ff == BK_WR_AP && cnt_ff == CNT_ZERO && !hit)
                    |=> (state_ff == BK_PRECHARGE && cnt_ff == RP_CNT))
                else $error("write auto precharge did not start precharge");
            AST_RDAP_PRE: assert property (@(posedge sys_clk) disable iff (!rstN)
                (hit && cmdIf.cmd == CMD_READ && cmdIf.autoPre) ##1 (!hit) [*3]
                    |=> (state_ff == BK_PRECHARGE))
                else $error("read auto precharge not precharging after burst");
        end
    endgenerate
endmodule

// >>> core/mbl_top.sv
`timescale 1ns/1ps
// Behaviour
// - chip select high is deselect, or terminator disable when the other pins give the read pattern; banks continue.
// - select with row, column, write enable high is a no-operation.
// - auto-precharge reads and writes precharge the bank themselves; plain ones return it to active.
// - read auto precharge starts where earliest explicit precharge would.
// - write auto precharge starts after write recovery, lasts row precharge.
// - bank idle only after precharge and row precharge time.
module mbl_top
    import mbl_pkg::*;
#(
    parameter int BURST_LENGTH  = DEF_BURST_LENGTH,
    parameter int WRITE_LAT     = DEF_WRITE_LAT,
    parameter int READ_LAT_RND  = DEF_READ_LAT_RND,
    parameter int ROW_TO_COL    = DEF_ROW_TO_COL,
    parameter int WRITE_RECOV   = DEF_WRITE_RECOV,
    parameter int ROW_PRECHARGE = DEF_ROW_PRECHARGE
) (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 chipSelN,
    input  wire logic                 rowStrobeN,
    input  wire logic                 colStrobeN,
    input  wire logic                 writeEnN,
    input  wire logic                 clkEn,
    input  wire logic [BANK_W-1:0]    bankAddr,
    input  wire logic                 autoPreBit,
    output logic                      cmdAccepted,
    output logic [3:0]                cmdCode,
    output logic                      termDisable,
    output logic                      allBanksIdle,
    output logic [NUM_BANKS-1:0]      bankIdleMask,
    output logic                      illegalCmd
);
    logic [1:0] rstSync_ff;
    logic       rstN;
    logic       cke1_ff;
    mbl_cmd_type nxt_cmd;
    logic       cmdLegal;
    logic       cmdAccepted_ff;
    logic [3:0] cmdCode_ff;
    logic       termDisable_ff;
    logic       illegal_ff;
    mbl_bank_type bankState [NUM_BANKS];
    mbl_bank_type tgtState;
    mbl_cmd_if  cmdIf ();

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rstSync_ff <= 2'h0;
        else       rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
    assign rstN = rstSync_ff[1];

    // clock enable at the previous edge; the current edge reads the pin itself
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cke1_ff <= 1'b0;
        end else begin
            cke1_ff <= clkEn;
        end
    end

    // pin decode
    always_comb begin
        nxt_cmd = CMD_NOP;
        // terminator disable shares its pin pattern with read, so only deselected
        if (chipSelN) begin
            if (rowStrobeN && !colStrobeN && writeEnN) begin
                nxt_cmd = CMD_TERM_DIS;
            end else begin
                nxt_cmd = CMD_DESELECT;
            end
        end else begin
            case ({rowStrobeN, colStrobeN, writeEnN})
                3'b111:  nxt_cmd = CMD_NOP;
                3'b011:  nxt_cmd = CMD_ACTIVE;
                3'b101:  nxt_cmd = CMD_READ;
                3'b100:  nxt_cmd = CMD_WRITE;
                3'b010:  nxt_cmd = CMD_PRECHARGE;
                3'b001:  nxt_cmd = CMD_REFRESH;
                3'b000:  nxt_cmd = CMD_LOAD_MODE;
                default: nxt_cmd = CMD_NOP;
            endcase
        end
    end

    assign tgtState = bankState[bankAddr];

    // legality of a command against the target bank's own state; refresh and mode load need every bank idle
    always_comb begin
        cmdLegal = 1'b1;
        case (nxt_cmd)
            CMD_ACTIVE:    cmdLegal = (tgtState == BK_IDLE);
            CMD_READ, CMD_WRITE:
                cmdLegal = (tgtState == BK_ACTIVE) || (tgtState == BK_READ)
                           || (tgtState == BK_WRITE);
            CMD_PRECHARGE: cmdLegal = (tgtState != BK_RD_AP) && (tgtState != BK_WR_AP);
            CMD_REFRESH, CMD_LOAD_MODE: cmdLegal = cmdIf.bankIdle == '1;
            default:       cmdLegal = 1'b1;
        endcase
    end

    // only execute when clock enable high on previous and current edge
    assign cmdIf.cmdValid = clkEn && cke1_ff && cmdLegal
                            && (nxt_cmd == CMD_ACTIVE || nxt_cmd == CMD_READ
                                || nxt_cmd == CMD_WRITE || nxt_cmd == CMD_PRECHARGE);
    assign cmdIf.cmd     = nxt_cmd;
    assign cmdIf.bank    = bankAddr;
    assign cmdIf.autoPre = autoPreBit;

    // registered status of the command just taken
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cmdAccepted_ff <= 1'b0;
            cmdCode_ff     <= 4'h0;
            termDisable_ff <= 1'b0;
            illegal_ff     <= 1'b0;
        end else begin
            cmdAccepted_ff <= cmdIf.cmdValid;
            cmdCode_ff     <= nxt_cmd;
            termDisable_ff <= (nxt_cmd == CMD_TERM_DIS);
            // flag commands not legal for the bank state; they are not executed
            illegal_ff     <= clkEn && cke1_ff && !cmdLegal;
        end
    end

    assign cmdAccepted  = cmdAccepted_ff;
    assign cmdCode      = cmdCode_ff;
    assign termDisable  = termDisable_ff;
    assign illegalCmd   = illegal_ff;
    assign bankIdleMask = cmdIf.bankIdle; // per-bank only
    assign allBanksIdle = (cmdIf.bankIdle == '1);

    mbl_bank_track #(
        .BURST_LENGTH  (BURST_LENGTH),
        .WRITE_LAT     (WRITE_LAT),
        .READ_LAT_RND  (READ_LAT_RND),
        .ROW_TO_COL    (ROW_TO_COL),
        .WRITE_RECOV   (WRITE_RECOV),
        .ROW_PRECHARGE (ROW_PRECHARGE)
    ) uTrack (
        .sys_clk   (sys_clk),
        .rstN      (rstN),
        .cmdIf     (cmdIf.trk),
        .bankState (bankState)
    );

    AST_DESEL_NOEXEC: assert property (@(posedge sys_clk) disable iff (!rstN)
        (chipSelN && !(rowStrobeN && !colStrobeN && writeEnN)) |=> !cmdAccepted)
        else $error("deselect executed a command");
    AST_NOP_NOEXEC: assert property (@(posedge sys_clk) disable iff (!rstN)
        (!chipSelN && rowStrobeN && colStrobeN && writeEnN) |=> (!cmdAccepted && cmdCode == 4'h1))
        else $error("nop not decoded");
    AST_CKE_GATE: assert property (@(posedge sys_clk) disable iff (!rstN)
        (!clkEn || !cke1_ff) |=> !cmdAccepted)
        else $error("command taken with clock enable low");
    AST_REFRESH_IDLE: assert property (@(posedge sys_clk) disable iff (!rstN)
        (clkEn && cke1_ff && nxt_cmd == CMD_REFRESH && !allBanksIdle) |=> illegalCmd)
        else $error("refresh with busy bank not flagged");
    AST_TERM_DIS: assert property (@(posedge sys_clk) disable iff (!rstN)
        (chipSelN && rowStrobeN && !colStrobeN && writeEnN) |=> termDisable)
        else $error("terminator disable missed");
    AST_ACT_STATE: assert property (@(posedge sys_clk) disable iff (!rstN)
        (cmdIf.cmdValid && nxt_cmd == CMD_ACTIVE) |=> (bankState[$past(bankAddr)] == BK_ACTIVATING))
        else $error("activate not tracked");

    // read moves the bank into the variant chosen by the auto precharge bit
    AST_READ_TRACK: assert property (@(posedge sys_clk) disable iff (!rstN)
        (cmdIf.cmdValid && nxt_cmd == CMD_READ)
            |=> (bankState[$past(bankAddr)] == ($past(autoPreBit) ? BK_RD_AP : BK_READ)))
        else $error("read not tracked");

    // write likewise for both variants
    AST_WRITE_TRACK: assert property (@(posedge sys_clk) disable iff (!rstN)
        (cmdIf.cmdValid && nxt_cmd == CMD_WRITE)
            |=> (bankState[$past(bankAddr)] == ($past(autoPreBit) ? BK_WR_AP : BK_WRITE)))
        else $error("write not tracked");

    // explicit precharge starts the row precharge period
    AST_PRE_TRACK: assert property (@(posedge sys_clk) disable iff (!rstN)
        (cmdIf.cmdValid && nxt_cmd == CMD_PRECHARGE)
            |=> (bankState[$past(bankAddr)] == BK_PRECHARGE))
        else $error("precharge not tracked");

    // mode load with a busy bank is refused like refresh
    AST_LOAD_IDLE: assert property (@(posedge sys_clk) disable iff (!rstN)
        (clkEn && cke1_ff && nxt_cmd == CMD_LOAD_MODE && !allBanksIdle) |=> illegalCmd)
        else $error("mode load with busy bank not flagged");

    // a command not legal for the bank state is flagged and never executed
    AST_ILLEGAL_NOEXEC: assert property (@(posedge sys_clk) disable iff (!rstN)
        (clkEn && cke1_ff && !cmdLegal) |=> (illegalCmd && !cmdAccepted))
        else $error("illegal command executed or not flagged");

    // with nothing executed an all-idle device stays idle
    AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (!rstN)
        (!cmdIf.cmdValid && allBanksIdle) |=> allBanksIdle)
        else $error("idle bank changed without a command");

    // every executed command is reported with its code one cycle later
    AST_ACCEPT_CODE: assert property (@(posedge sys_clk) disable iff (!rstN)
        cmdIf.cmdValid |=> (cmdAccepted && cmdCode == $past(nxt_cmd)))
        else $error("executed command not reported");

    // terminator disable never reaches the banks
    AST_TERM_NOEXEC: assert property (@(posedge sys_clk) disable iff (!rstN)
        (chipSelN && rowStrobeN && !colStrobeN && writeEnN) |=> !cmdAccepted)
        else $error("terminator disable executed a command");
endmodule

// >>> bench/mbl_ctrl_model.sv
`timescale 1ns/1ps
// behavioural memory controller on the command pins
module mbl_ctrl_model
    import mbl_pkg::*;
(
    input  wire logic          sys_clk,
    output logic               chipSelN,
    output logic               rowStrobeN,
    output logic               colStrobeN,
    output logic               writeEnN,
    output logic               clkEn,
    output logic [BANK_W-1:0]  bankAddr,
    output logic               autoPreBit
);
    logic [2:0] nxtPins;
    // start deselected with clock enable high
    initial begin
        {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hF;
        clkEn = 1'b1;
        bankAddr = 3'h0;
        autoPreBit = 1'b0;
    end
    // one command held over exactly one rising edge; caller keeps spacing
    task automatic send(input mbl_cmd_type c, input logic [BANK_W-1:0] b, input logic ap);
        @(negedge sys_clk);
        bankAddr = b;
        autoPreBit = ap;
        case (c)
            CMD_ACTIVE:    {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h3;
            CMD_READ:      {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h5;
            CMD_WRITE:     {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h4;
            CMD_PRECHARGE: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h2;
            CMD_REFRESH:   {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h1;
            CMD_LOAD_MODE: {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h0;
            CMD_NOP:       {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'h7;
            CMD_TERM_DIS:  {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hD;
            default:       {chipSelN, rowStrobeN, colStrobeN, writeEnN} = 4'hB;
        endcase
    endtask
    // deselect; stale lines flip so old values cannot pass for a command
    task automatic release_bus();
        @(negedge sys_clk);
        nxtPins = ~{rowStrobeN, colStrobeN, writeEnN};
        if (nxtPins == 3'h5) nxtPins = 3'h4; // avoid a stray terminator disable
        chipSelN = 1'b1;
        {rowStrobeN, colStrobeN, writeEnN} = nxtPins;
        bankAddr = ~bankAddr;
        autoPreBit = ~autoPreBit;
    endtask
    // clock enable changes only off the sampling edge
    task automatic set_cke(input logic v);
        @(negedge sys_clk);
        clkEn = v;
    endtask
endmodule

// >>> bench/multibank_command_legality_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module multibank_command_legality_bench;
    import mbl_pkg::*;
    localparam int HB = DEF_BURST_LENGTH / 2;
    logic sys_clk, nrst, chipSelN, rowStrobeN, colStrobeN, writeEnN, clkEn, autoPreBit;
    logic [BANK_W-1:0] bankAddr;
    logic cmdAccepted, termDisable, allBanksIdle, illegalCmd;
    logic [3:0] cmdCode, lastCode;
    logic [NUM_BANKS-1:0] bankIdleMask;
    int fail_count, samples_checked, cyc, accCount, illCount, tdCount, a0, i0, t0, t1;
    mbl_ctrl_model i_ctrl(.sys_clk, .chipSelN, .rowStrobeN, .colStrobeN, .writeEnN,
        .clkEn, .bankAddr, .autoPreBit);
    mbl_top i_dut(.sys_clk, .nrst, .chipSelN, .rowStrobeN, .colStrobeN, .writeEnN, .clkEn,
        .bankAddr, .autoPreBit, .cmdAccepted, .cmdCode, .termDisable, .allBanksIdle,
        .bankIdleMask, .illegalCmd);
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    // pulse counters read before the edge's updates land; also the hang limit
    always @(posedge sys_clk) begin
        cyc++;
        if (cmdAccepted === 1'b1) accCount++;
        if (illegalCmd === 1'b1) illCount++;
        if (termDisable === 1'b1) tdCount++;
        if (cmdCode !== CMD_NOP && cmdCode !== CMD_DESELECT && cmdCode !== CMD_TERM_DIS)
            lastCode = cmdCode;
        if (cyc > 3000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask
    // bounded wait for a bank to report idle, returns the cycle stamp
    task automatic wait_idle(input int b, output int t);
        repeat (80) if (bankIdleMask[b] !== 1'b1) @(negedge sys_clk);
        t = cyc;
    endtask
    task automatic t_quiet();
        a0 = accCount;
        t0 = tdCount;
        i_ctrl.send(CMD_DESELECT, 3'h0, 1'b0);
        i_ctrl.send(CMD_NOP, 3'h1, 1'b0);
        i_ctrl.send(CMD_TERM_DIS, 3'h2, 1'b0);
        i_ctrl.release_bus();
        settle();
        `CHK("accepted", a0, accCount)
        `CHK("idle mask", 8'hFF, bankIdleMask)
        `CHK("term disable", t0 + 1, tdCount)
        i_ctrl.set_cke(1'b0);
        i_ctrl.send(CMD_ACTIVE, 3'h2, 1'b0);
        i_ctrl.release_bus();
        i_ctrl.set_cke(1'b1);
        settle();
        `CHK("cke low", 8'hFF, bankIdleMask)
        $display("quiet test done");
    endtask
    task automatic t_banks();
        a0 = accCount;
        i_ctrl.send(CMD_ACTIVE, 3'h0, 1'b0);
        i_ctrl.send(CMD_ACTIVE, 3'h1, 1'b0);
        i_ctrl.release_bus();
        settle();
        `CHK("two actives", a0 + 2, accCount)
        `CHK("code", CMD_ACTIVE, lastCode)
        `CHK("busy mask", 8'hFC, bankIdleMask)
        repeat (DEF_ROW_TO_COL) @(negedge sys_clk);
        a0 = illCount;
        i_ctrl.send(CMD_REFRESH, 3'h0, 1'b0);
        i_ctrl.release_bus();
        settle();
        `CHK("refresh busy", a0 + 1, illCount)
        a0 = accCount;
        i_ctrl.send(CMD_READ, 3'h0, 1'b1);
        t0 = cyc;
        i_ctrl.release_bus();
        fork
            wait_idle(0, i0);
            begin
                // read-ap to other-bank write spacing
                repeat (DEF_READ_LAT_RND + HB + 1 - DEF_WRITE_LAT) @(negedge sys_clk);
                i_ctrl.send(CMD_WRITE, 3'h1, 1'b1);
                t1 = cyc;
                i_ctrl.release_bus();
                wait_idle(1, a0);
                a0 = a0 - t1;
            end
        join
        `CHK("read ap idle", 1, i0 - t0 >= HB + DEF_ROW_PRECHARGE)
        `CHK("read ap late", 1, i0 - t0 <= HB + DEF_ROW_PRECHARGE + 4)
        `CHK("write ap idle", 1, a0 >= DEF_WRITE_LAT + HB + DEF_WRITE_RECOV
            + DEF_ROW_PRECHARGE)
        `CHK("write ap late", 1, a0 <= DEF_WRITE_LAT + HB + DEF_WRITE_RECOV
            + DEF_ROW_PRECHARGE + 4)
        `CHK("all idle", 1'b1, allBanksIdle)
        $display("bank test done");
    endtask
    task automatic t_global();
        a0 = illCount;
        i_ctrl.send(CMD_REFRESH, 3'h5, 1'b0);
        i_ctrl.release_bus();
        settle();
        `CHK("refresh", CMD_REFRESH, lastCode)
        i_ctrl.send(CMD_LOAD_MODE, 3'h2, 1'b0);
        i_ctrl.release_bus();
        settle();
        `CHK("load mode", CMD_LOAD_MODE, lastCode)
        `CHK("no refusal", a0, illCount)
        i_ctrl.send(CMD_ACTIVE, 3'h3, 1'b0);
        i_ctrl.release_bus();
        repeat (DEF_ROW_TO_COL + 1) @(negedge sys_clk);
        i_ctrl.send(CMD_PRECHARGE, 3'h3, 1'b0);
        t0 = cyc;
        i_ctrl.release_bus();
        wait_idle(3, i0);
        `CHK("precharge code", CMD_PRECHARGE, lastCode)
        `CHK("row precharge", 1, i0 - t0 >= DEF_ROW_PRECHARGE)
        `CHK("precharge late", 1, i0 - t0 <= DEF_ROW_PRECHARGE + 3)
        $display("global test done");
    endtask
    // reset held eight cycles, then the tests in turn
    initial begin
        nrst = 1'b0;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK("reset idle", 1'b1, allBanksIdle)
        `CHK("reset mask", 8'hFF, bankIdleMask)
        $display("reset test done");
        t_quiet();
        t_banks();
        t_global();
        summarize();
    end
endmodule
